// ---- rtl/rsc_defs.vh ----
// Constants for the rotator shift control block
// How it works
// - Code 28 picks outputs by data size: extract at size 0, shift left otherwise
// - Codes 28 and 29 force a zero result when position bits four to zero are zero
// - Code 23 passes the R bus to the shifter when position bits four to zero are zero
// - Code 20 passes the R bus when position and size low bits are both zero
// - Extract codes 0 to 2: shift places the field, secondary gives its length
// - Extract shift bits four to two come from position bits four to two
// - Extract shift bits one and zero come from position bits one and zero
// - Secondary bits 5 and 3..0 come from position low bits plus size minus one
// - Secondary bit four is sum bit five or else sum bit four
// - Codes 20 to 23 rotate left with secondary 3F, shift minus position plus size at 20, minus position at 21 to 23
// - Codes 24 to 26 rotate right with secondary 3F, shift position plus size
// - Codes 27 and 2F take their shift from the zero-byte flags
// - Codes 29 to 2B use primary 3 and shift by minus position
// - Codes 2C to 2E use primary 3, low byte float, shifts C, 8, 18
// - Codes 30 to 37 use zero literal with shifts 0 up to 1C by 4
// - Codes 38 to 3F use one literal with shifts 0, 8, 10 or 18
// - Code 39 forces the literal to all ones
// - Two status bits are produced every microcycle
// - Tests 0,1,2,4,5,6: bit1 is size zero, bit0 is position plus size above 32
// - Tests 3 and 7: bit1 is zero, bit0 is position bit five
// - Leftmost nonzero byte shift bits four and three follow the zero-byte flags
// - Zero literal is zero-extended and rotated right by the shift
// - One literal is one-extended and rotated when secondary bit four is high
// - Low byte float drives bits 31 to 8 zero and floats bits 7 to 0
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_PRI_EXT_MR   2'h0
`define RSC_PRI_EXT_MM   2'h1
`define RSC_PRI_EXT_RR   2'h2
`define RSC_PRI_SEC      2'h3
`define RSC_SEC_ALL      6'h3f
`define RSC_SEC_EXT_SZ0  6'h34
`define RSC_SEC_SHIFT_LEFT_R_SOURCE    6'h34
`define RSC_SEC_SHIFT_LEFT_M_SOURCE    6'h35
`define RSC_SEC_SHIFT_RIGHT_M_SOURCE    6'h3c
`define RSC_SEC_ZLIT_3   6'h37
`define RSC_SEC_ZLIT_2   6'h27
`define RSC_SEC_ZLIT_0   6'h07
`define RSC_SEC_OLIT_3   6'h36
`define RSC_SEC_OLIT_2   6'h26
`define RSC_SEC_OLIT_0   6'h06
`define RSC_SEC_LBF_1    6'h12
`define RSC_SEC_LBF_3    6'h32
`define RSC_SEC_LBF_0    6'h02
`define RSC_SEC_NONE     6'h00
`define RSC_SEC_LEN_MSB  4
`define RSC_SEC_LIT_EXT  4
`define RSC_SEC_TYPE_ZLIT 4'h7
`define RSC_SEC_TYPE_OLIT 4'h6
`define RSC_SEC_TYPE_LBF  4'h2
`define RSC_SHF_ZERO     5'h00
`define RSC_SHF_1F       5'h1f
`define RSC_SHF_1E       5'h1e
`define RSC_SHF_1D       5'h1d
`define RSC_SHF_04       5'h04
`define RSC_SHF_08       5'h08
`define RSC_SHF_0C       5'h0c
`define RSC_SHF_10       5'h10
`define RSC_SHF_14       5'h14
`define RSC_SHF_18       5'h18
`define RSC_SHF_1C       5'h1c
`define RSC_NIB_3        2'h3
`define RSC_NIB_2        2'h2
`define RSC_NIB_1        2'h1
`define RSC_NIB_0        2'h0
`define RSC_FIELD_LIMIT  7'h20
`define RSC_LATCH_RESET  6'h00
`define RSC_ROT_XZ_MR    6'h00
`define RSC_ROT_XZ_MM    6'h01
`define RSC_ROT_XZ_RR    6'h02
`define RSC_ROT_RL_PS    6'h20
`define RSC_ROT_RL_MM    6'h21
`define RSC_ROT_RL_RR    6'h22
`define RSC_ROT_RL_RM    6'h23
`define RSC_ROT_RR_MR    6'h24
`define RSC_ROT_RR_MM    6'h25
`define RSC_ROT_RR_RR    6'h26
`define RSC_ROT_LMNZ     6'h27
`define RSC_ROT_SHIFT_LEFT_R_SOURCE    6'h28
`define RSC_ROT_SHIFT_LEFT_M_SOURCE    6'h29
`define RSC_ROT_SHIFT_RIGHT_M_SOURCE    6'h2a
`define RSC_ROT_ZLIT_PL  6'h2b
`define RSC_ROT_LBF_C    6'h2c
`define RSC_ROT_LBF_8    6'h2d
`define RSC_ROT_LBF_18   6'h2e
`define RSC_ROT_LBF_NZ   6'h2f
`define RSC_ROT_ZLIT_LO  6'h30
`define RSC_ROT_ZLIT_HI  6'h37
`define RSC_ROT_OLIT_LO  6'h38
`define RSC_ROT_ALL_ONES_CONSTANT   6'h39
`define RSC_ROT_OLIT_HI  6'h3f
`define RSC_ST_PL5_A     6'h03
`define RSC_ST_PL5_B     6'h07
`endif

// ---- rtl/rsc_rotator_control_unit.v ----
// Rotator shift control: function decode, extract field encoding and status
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.vh"

module rsc_rotator_control_unit #(
	parameter LIT_W = 9
) (
	input  wire             mclk,
	input  wire             rst_n,
	input  wire             load_position,
	input  wire [5:0]       position_in,
	input  wire             load_size,
	input  wire [5:0]       size_in,
	input  wire [5:0]       rotate_function_code,
	input  wire [5:0]       status_test_select,
	input  wire [1:0]       data_size,
	input  wire [3:0]       zero_byte_flags,
	input  wire [LIT_W-1:0] microword_literal,
	output reg  [1:0]       primary_function_sel,
	output reg  [5:0]       secondary_function_sel,
	output reg  [4:0]       shift_amount_out,
	output reg              force_zero_result,
	output reg              pass_r_source,
	output wire [LIT_W-1:0] literal_to_slice,
	output reg  [31:0]      literal_word,
	output wire             shifter_high_zero,
	output wire             shifter_low_oe_n,
	output reg  [1:0]       rotator_status_out,
	output wire [5:0]       position_latch,
	output wire [5:0]       size_latch
);

	// ------------------------------------------------------------
	// Position and size latches
	// ------------------------------------------------------------
	reg  [5:0] pos_q;
	reg  [5:0] size_q;
	wire [5:0] next_pos;
	wire [5:0] next_size;

	// Latches change only on a load strobe; reset clears both to zero
	assign next_pos  = load_position ? position_in : pos_q;
	assign next_size = load_size ? size_in : size_q;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q  <= `RSC_LATCH_RESET;
			size_q <= `RSC_LATCH_RESET;
		end else begin
			pos_q  <= next_pos;
			size_q <= next_size;
		end
	end

	assign position_latch = pos_q;
	assign size_latch     = size_q;

	// ------------------------------------------------------------
	// Derived arithmetic
	// ------------------------------------------------------------
	wire [6:0] field_sum;
	wire [5:0] ext_sec;
	wire [4:0] pos_plus_size;
	wire [4:0] neg_pos;
	wire [4:0] neg_pos_size;
	wire [4:0] nz_byte_shf;
	reg  [1:0] nz_nib;
	wire       pos_low_zero;
	wire       size_low_zero;
	wire [6:0] status_sum;

	// position low bits plus size minus one
	assign field_sum = {5'h00, pos_q[1:0]} + {1'b0, size_q} - 7'h01;
	assign ext_sec = {field_sum[5], field_sum[5] | field_sum[4], field_sum[3:0]};

	// Minus shifts wrap modulo 32, which is the rotator's own range
	assign pos_plus_size = pos_q[4:0] + size_q[4:0];
	assign neg_pos       = 5'h00 - pos_q[4:0];
	assign neg_pos_size  = 5'h00 - pos_plus_size;
	assign pos_low_zero  = (pos_q[4:0] == 5'h00);
	assign size_low_zero = (size_q[4:0] == 5'h00);

	// ------------------------------------------------------------
	// Leftmost nonzero byte
	// ------------------------------------------------------------
	// first clear flag from the top wins
	always @* begin
		if (!zero_byte_flags[3])
			nz_nib = `RSC_NIB_3;
		else if (!zero_byte_flags[2])
			nz_nib = `RSC_NIB_2;
		else if (!zero_byte_flags[1])
			nz_nib = `RSC_NIB_1;
		else
			nz_nib = `RSC_NIB_0;
	end
	assign nz_byte_shf = {nz_nib, 3'b000};

	// ------------------------------------------------------------
	// Rotate function decode
	// ------------------------------------------------------------
	// purely combinational decode
	always @* begin
		primary_function_sel   = `RSC_PRI_SEC;
		secondary_function_sel = `RSC_SEC_NONE;
		shift_amount_out       = `RSC_SHF_ZERO;
		force_zero_result      = 1'b0;
		pass_r_source          = 1'b0;
		// Codes 03 to 1F fall through to the defaults: primary 3, no secondary
		case (rotate_function_code)
		`RSC_ROT_XZ_MR, `RSC_ROT_XZ_MM, `RSC_ROT_XZ_RR: begin
			primary_function_sel   = rotate_function_code[1:0];
			secondary_function_sel = ext_sec;
			shift_amount_out[4:2]  = pos_q[4:2];
			// final bit shift for the arithmetic slice
			shift_amount_out[1:0]  = pos_q[1:0];
		end
		// rotate left by position plus size
		`RSC_ROT_RL_PS: begin
			primary_function_sel   = `RSC_PRI_EXT_MR;
			secondary_function_sel = `RSC_SEC_ALL;
			shift_amount_out       = neg_pos_size;
			pass_r_source          = pos_low_zero & size_low_zero;
		end
		`RSC_ROT_RL_MM, `RSC_ROT_RL_RR, `RSC_ROT_RL_RM: begin
			primary_function_sel   = (rotate_function_code == `RSC_ROT_RL_RR) ?
				`RSC_PRI_EXT_RR : (rotate_function_code == `RSC_ROT_RL_MM) ?
				`RSC_PRI_EXT_MM : `RSC_PRI_EXT_MR;
			secondary_function_sel = `RSC_SEC_ALL;
			shift_amount_out       = neg_pos;
			pass_r_source          = (rotate_function_code == `RSC_ROT_RL_RM) & pos_low_zero;
		end
		// rotate right by position plus size
		`RSC_ROT_RR_MR, `RSC_ROT_RR_MM, `RSC_ROT_RR_RR: begin
			primary_function_sel   = rotate_function_code[1:0];
			secondary_function_sel = `RSC_SEC_ALL;
			shift_amount_out       = pos_plus_size;
		end
		// leftmost nonzero byte to low byte
		`RSC_ROT_LMNZ: begin
			primary_function_sel   = `RSC_PRI_EXT_MM;
			secondary_function_sel = `RSC_SEC_ALL;
			shift_amount_out       = nz_byte_shf;
		end
		// shift left R by data size
		`RSC_ROT_SHIFT_LEFT_R_SOURCE: begin
			force_zero_result = pos_low_zero;
			// Byte size turns this into an extract of the low byte
			case (data_size)
			2'h0: begin
				primary_function_sel   = `RSC_PRI_EXT_RR;
				secondary_function_sel = `RSC_SEC_EXT_SZ0;
				shift_amount_out       = `RSC_SHF_ZERO;
			end
			2'h1: begin
				secondary_function_sel = `RSC_SEC_SHIFT_LEFT_R_SOURCE;
				shift_amount_out       = `RSC_SHF_1F;
			end
			2'h2: begin
				secondary_function_sel = `RSC_SEC_SHIFT_LEFT_R_SOURCE;
				shift_amount_out       = `RSC_SHF_1E;
			end
			default: begin
				secondary_function_sel = `RSC_SEC_SHIFT_LEFT_R_SOURCE;
				shift_amount_out       = `RSC_SHF_1D;
			end
			endcase
		end
		`RSC_ROT_SHIFT_LEFT_M_SOURCE: begin
			secondary_function_sel = `RSC_SEC_SHIFT_LEFT_M_SOURCE;
			shift_amount_out       = neg_pos;
			force_zero_result      = pos_low_zero;
		end
		`RSC_ROT_SHIFT_RIGHT_M_SOURCE: begin
			secondary_function_sel = `RSC_SEC_SHIFT_RIGHT_M_SOURCE;
			shift_amount_out       = neg_pos;
		end
		`RSC_ROT_ZLIT_PL: begin
			secondary_function_sel = `RSC_SEC_ZLIT_3;
			shift_amount_out       = neg_pos;
		end
		`RSC_ROT_LBF_C: begin
			secondary_function_sel = `RSC_SEC_LBF_1;
			shift_amount_out       = `RSC_SHF_0C;
		end
		`RSC_ROT_LBF_8: begin
			secondary_function_sel = `RSC_SEC_LBF_1;
			shift_amount_out       = `RSC_SHF_08;
		end
		`RSC_ROT_LBF_18: begin
			secondary_function_sel = `RSC_SEC_LBF_3;
			shift_amount_out       = `RSC_SHF_18;
		end
		`RSC_ROT_LBF_NZ: begin
			secondary_function_sel = `RSC_SEC_LBF_0;
			shift_amount_out       = nz_byte_shf;
		end
		default: begin
			if (rotate_function_code >= `RSC_ROT_ZLIT_LO &&
			    rotate_function_code <= `RSC_ROT_ZLIT_HI) begin
				shift_amount_out = {rotate_function_code[2:0], 2'b00};
				case (rotate_function_code[2:0])
				3'h0, 3'h4: secondary_function_sel = `RSC_SEC_ZLIT_0;
				3'h5:       secondary_function_sel = `RSC_SEC_ZLIT_2;
				default:    secondary_function_sel = `RSC_SEC_ZLIT_3;
				endcase
			end else if (rotate_function_code >= `RSC_ROT_OLIT_LO) begin
				// one literal, byte placements on even codes
				shift_amount_out = rotate_function_code[0] ? `RSC_SHF_ZERO :
					{rotate_function_code[2:1], 3'b000};
				case (rotate_function_code[2:0])
				3'h1:             secondary_function_sel = `RSC_SEC_OLIT_3;
				3'h2, 3'h3, 3'h6: secondary_function_sel = `RSC_SEC_OLIT_2;
				default:          secondary_function_sel = `RSC_SEC_OLIT_0;
				endcase
			end
		end
		endcase
	end

	// ------------------------------------------------------------
	// Literal and low byte handling
	// ------------------------------------------------------------
	wire        lit_ones_sel;
	wire        zero_extended_literal_sel;
	wire        lbf_sel;
	wire [63:0] lit_doubled;
	wire [31:0] lit_ext;

	// Forcing here lets the one-extend path also make the all-ones constant
	// minus one forces the literal high
	assign literal_to_slice = (rotate_function_code == `RSC_ROT_ALL_ONES_CONSTANT) ?
		{LIT_W{1'b1}} : microword_literal;

	assign zero_extended_literal_sel = (primary_function_sel == `RSC_PRI_SEC) &&
		(secondary_function_sel[3:0] == `RSC_SEC_TYPE_ZLIT);
	assign lit_ones_sel = (primary_function_sel == `RSC_PRI_SEC) &&
		(secondary_function_sel[3:0] == `RSC_SEC_TYPE_OLIT);
	assign lbf_sel      = (primary_function_sel == `RSC_PRI_SEC) &&
		(secondary_function_sel[3:0] == `RSC_SEC_TYPE_LBF);

	// Extension is chosen ahead of the rotation so no process reads its own output
	// The literal fills the low bits; the upper bits follow the extension
	assign lit_ext = lit_ones_sel ?
		{{(32-LIT_W){1'b1}}, literal_to_slice} :
		{{(32-LIT_W){1'b0}}, literal_to_slice};

	// Rotation done on a doubled word so no wrap logic is needed
	assign lit_doubled = {lit_ext, lit_ext} >> shift_amount_out;

	always @* begin
		literal_word = 32'h0000_0000;
		if (zero_extended_literal_sel) begin
			literal_word = lit_doubled[31:0];
		end else if (lit_ones_sel) begin
			// one-extend and rotate, or all ones
			literal_word = secondary_function_sel[`RSC_SEC_LIT_EXT] ?
				lit_doubled[31:0] : 32'hffff_ffff;
		end
	end

	// The low byte enable is active low: high means the byte is released
	// upper bits zero, low byte released
	assign shifter_high_zero = lbf_sel;
	assign shifter_low_oe_n  = lbf_sel;

	// ------------------------------------------------------------
	// Microbranch status
	// ------------------------------------------------------------
	assign status_sum = {2'b00, pos_q[4:0]} + {1'b0, size_q};

	// Codes above seven belong to other tests and read back as zero
	// both bits valid every microcycle
	always @* begin
		rotator_status_out = 2'b00;
		if (status_test_select[5:3] == 3'b000) begin
			if (status_test_select == `RSC_ST_PL5_A || status_test_select == `RSC_ST_PL5_B) begin
				rotator_status_out = {1'b0, pos_q[5]};
			end else begin
				rotator_status_out = {size_q == 6'h00, status_sum > `RSC_FIELD_LIMIT};
			end
		end
	end

endmodule // rsc_rotator_control_unit
`default_nettype wire

// ---- bench/rsc_sequencer_model.sv ----
// Microsequencer model that hands the status test field to the block
`timescale 1ns/1ps
`default_nettype none
module rsc_sequencer_model (
	input  wire logic [63:0] microword,
	output logic      [5:0]  status_test_select
);
	assign status_test_select = microword[63:58];
endmodule // rsc_sequencer_model
`default_nettype wire

// ---- bench/rsc_checker.sv ----
// Port-level assertions for the rotator shift control block
`timescale 1ns/1ps
`default_nettype none
module rsc_checker #(
	parameter int LIT_W = 9
) (
	input wire logic             mclk,
	input wire logic             rst_n,
	input wire logic [5:0]       rotate_function_code,
	input wire logic [5:0]       status_test_select,
	input wire logic [LIT_W-1:0] literal_to_slice,
	input wire logic [5:0]       secondary_function_sel,
	input wire logic [4:0]       shift_amount_out,
	input wire logic             force_zero_result,
	input wire logic             pass_r_source,
	input wire logic             shifter_high_zero,
	input wire logic             shifter_low_oe_n,
	input wire logic [1:0]       rotator_status_out,
	input wire logic [5:0]       position_latch,
	input wire logic [5:0]       size_latch
);
	wire [5:0] rc = rotate_function_code;
	wire [5:0] ts = status_test_select;
	wire [6:0] ext_sum = {5'h00, position_latch[1:0]} + {1'b0, size_latch} - 7'h01;
	wire [5:0] ext_sec = {ext_sum[5], ext_sum[5] | ext_sum[4], ext_sum[3:0]};
	wire [6:0] fld_sum = {2'h0, position_latch[4:0]} + {1'b0, size_latch};
	wire [1:0] fld_stat = {size_latch == 6'h00, fld_sum > 7'h20};
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ext_shift: assert property (rc <= 6'h02 |-> shift_amount_out == position_latch[4:0])
		else $error("extract shift not taken from position");
	a_ext_len: assert property (rc <= 6'h02 |-> secondary_function_sel == ext_sec)
		else $error("extract length code wrong");
	a_rot_all: assert property (rc >= 6'h20 && rc <= 6'h26
		|-> secondary_function_sel == 6'h3f)
		else $error("rotate secondary not 3f");
	a_zlit_shift: assert property (rc[5:3] == 3'h6 |-> shift_amount_out == {rc[2:0], 2'h0})
		else $error("zero literal shift wrong");
	a_all_ones: assert property (rc == 6'h39 |-> &literal_to_slice)
		else $error("literal not forced to ones");
	a_asl_zero: assert property ((rc == 6'h28 || rc == 6'h29)
		&& position_latch[4:0] == 5'h00 |-> force_zero_result)
		else $error("zero result not forced");
	a_pass_r: assert property (rc == 6'h23 && position_latch[4:0] == 5'h00 |-> pass_r_source)
		else $error("R bus not passed");
	a_lbf_float: assert property (rc >= 6'h2c && rc <= 6'h2f
		|-> shifter_high_zero && shifter_low_oe_n)
		else $error("low byte not floated");
	a_stat_fld: assert property (ts <= 6'h07 && ts[1:0] != 2'h3
		|-> rotator_status_out == fld_stat)
		else $error("field status wrong");
	a_stat_pl5: assert property (ts <= 6'h07 && ts[1:0] == 2'h3
		|-> rotator_status_out == {1'b0, position_latch[5]})
		else $error("sign status wrong");
endmodule // rsc_checker
bind rsc_rotator_control_unit rsc_checker #(.LIT_W(LIT_W)) u_chk (
	.mclk, .rst_n, .rotate_function_code, .status_test_select, .literal_to_slice,
	.secondary_function_sel, .shift_amount_out, .force_zero_result, .pass_r_source,
	.shifter_high_zero, .shifter_low_oe_n, .rotator_status_out, .position_latch, .size_latch
);
`default_nettype wire

// ---- bench/tb_rsc_rotator_control_unit.sv ----
// Self-checking testbench for the rotator shift control block
`timescale 1ns/1ps
`default_nettype none
module tb_rsc_rotator_control_unit;
	// Tables are packed with entry 0 in the low bits
	localparam logic [47:0] zsec = {6'h37, 6'h37, 6'h27, 6'h07, 6'h37, 6'h37, 6'h37, 6'h07};
	localparam logic [47:0] osec = {6'h06, 6'h26, 6'h06, 6'h06, 6'h26, 6'h26, 6'h36, 6'h06};
	localparam logic [39:0] oshf = {5'h00, 5'h18, 5'h00, 5'h10, 5'h00, 5'h08, 5'h00, 5'h00};
	localparam logic [15:0] flags = {4'he, 4'hd, 4'hb, 4'h7};
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        load_position = 1'b0;
	logic        load_size = 1'b0;
	logic [5:0]  position_in = 6'h00;
	logic [5:0]  size_in = 6'h00;
	logic [5:0]  rotate_function_code = 6'h00;
	logic [63:0] microword = 64'h0;
	logic [1:0]  data_size = 2'h0;
	logic [3:0]  zero_byte_flags = 4'hf;
	logic [8:0]  microword_literal = 9'h000;
	wire  [5:0]  status_test_select;
	wire  [1:0]  primary_function_sel;
	wire  [5:0]  secondary_function_sel;
	wire  [4:0]  shift_amount_out;
	wire         force_zero_result;
	wire         pass_r_source;
	wire  [8:0]  literal_to_slice;
	wire  [31:0] literal_word;
	wire         shifter_high_zero;
	wire         shifter_low_oe_n;
	wire  [1:0]  rotator_status_out;
	wire  [5:0]  position_latch;
	wire  [5:0]  size_latch;
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;
	rsc_sequencer_model u_seq (
		.microword,
		.status_test_select
	);
	rsc_rotator_control_unit #(.LIT_W(9)) u_dut (
		.mclk, .rst_n, .load_position, .position_in, .load_size, .size_in,
		.rotate_function_code, .status_test_select, .data_size, .zero_byte_flags,
		.microword_literal, .primary_function_sel, .secondary_function_sel,
		.shift_amount_out, .force_zero_result, .pass_r_source, .literal_to_slice,
		.literal_word, .shifter_high_zero, .shifter_low_oe_n, .rotator_status_out,
		.position_latch, .size_latch
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic fail(input string msg);
		error_cnt++;
		$display("CHECK FAILED at %0t: %s", $time, msg);
	endtask
	task automatic stop_test();
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic load(input logic [5:0] p, input logic [5:0] s);
		@(negedge mclk);
		position_in = p;
		size_in = s;
		load_position = 1'b1;
		load_size = 1'b1;
		@(negedge mclk);
		load_position = 1'b0;
		load_size = 1'b0;
	endtask
	// Outputs are combinational, so look just after the next rising edge
	task automatic apply(input logic [5:0] code);
		@(negedge mclk);
		rotate_function_code = code;
		@(posedge mclk);
		#1;
	endtask
	task automatic chk_ctl(input logic [5:0] c, input logic [1:0] p, input logic [5:0] s,
		input logic [4:0] f);
		apply(c);
		checked++;
		if (primary_function_sel !== p || secondary_function_sel !== s || shift_amount_out !== f)
			fail("control outputs");
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) fail("flag output");
	endtask
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) fail("literal output");
	endtask
	task automatic cmp_stat(input logic [1:0] exp);
		checked++;
		if (rotator_status_out !== exp) fail("status bits");
	endtask
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		logic [5:0] p;
		logic [5:0] s;
		logic [1:0] e;
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		load(6'h05, 6'h08);
		cmp_word({20'h0, position_latch, size_latch}, 32'h0000_0148);
		chk_ctl(6'h00, 2'h0, 6'h08, 5'h05);
		chk_ctl(6'h01, 2'h1, 6'h08, 5'h05);
		load(6'h03, 6'h20);
		chk_ctl(6'h02, 2'h2, 6'h32, 5'h03);
		chk_ctl(6'h10, 2'h3, 6'h00, 5'h00);
		for (int i = 0; i < 7; i++)
			chk_ctl(6'h20 + 6'(i), 2'(i < 3 ? i : i == 3 ? 0 : i - 4), 6'h3f,
				i < 4 ? 5'h1d : 5'h03);
		for (int k = 0; k < 4; k++) begin
			@(negedge mclk) data_size = 2'(k);
			chk_ctl(6'h28, k == 0 ? 2'h2 : 2'h3, 6'h34, 5'(32 - k));
		end
		chk_ctl(6'h29, 2'h3, 6'h35, 5'h1d);
		chk_ctl(6'h2a, 2'h3, 6'h3c, 5'h1d);
		chk_ctl(6'h2b, 2'h3, 6'h37, 5'h1d);
		chk_ctl(6'h2c, 2'h3, 6'h12, 5'h0c);
		cmp_bit(shifter_high_zero & shifter_low_oe_n, 1'b1);
		chk_ctl(6'h2d, 2'h3, 6'h12, 5'h08);
		chk_ctl(6'h2e, 2'h3, 6'h32, 5'h18);
		for (int j = 0; j < 4; j++) begin
			@(negedge mclk) zero_byte_flags = flags[4*j +: 4];
			chk_ctl(6'h27, 2'h1, 6'h3f, 5'(24 - 8 * j));
			chk_ctl(6'h2f, 2'h3, 6'h02, 5'(24 - 8 * j));
		end
		@(negedge mclk) microword_literal = 9'h1ff;
		for (int i = 0; i < 8; i++)
			chk_ctl(6'h30 + 6'(i), 2'h3, zsec[6*i +: 6], 5'(4 * i));
		cmp_bit(shifter_low_oe_n, 1'b0);
		chk_ctl(6'h31, 2'h3, 6'h37, 5'h04);
		cmp_word(literal_word, 32'hf000001f);
		@(negedge mclk) microword_literal = 9'h0a5;
		for (int i = 0; i < 8; i++)
			chk_ctl(6'h38 + 6'(i), 2'h3, osec[6*i +: 6], oshf[5*i +: 5]);
		chk_ctl(6'h38, 2'h3, 6'h06, 5'h00);
		cmp_word(literal_word, 32'hffffffff);
		cmp_word({23'h0, literal_to_slice}, 32'h000000a5);
		chk_ctl(6'h39, 2'h3, 6'h36, 5'h00);
		cmp_word({23'h0, literal_to_slice}, 32'h000001ff);
		load(6'h20, 6'h01);
		apply(6'h28);
		cmp_bit(force_zero_result, 1'b1);
		apply(6'h29);
		cmp_bit(force_zero_result, 1'b1);
		apply(6'h23);
		cmp_bit(pass_r_source, 1'b1);
		apply(6'h20);
		cmp_bit(pass_r_source, 1'b0);
		load(6'h03, 6'h01);
		apply(6'h28);
		cmp_bit(force_zero_result, 1'b0);
		for (int n = 0; n < 3; n++) begin
			p = n == 0 ? 6'h03 : n == 1 ? 6'h22 : 6'h00;
			s = n == 2 ? 6'h00 : 6'h1e;
			load(p, s);
			for (int t = 0; t < 10; t++) begin
				@(negedge mclk) microword = {6'(t), 58'h0};
				@(posedge mclk) #1;
				e = {s == 6'h00, {2'h0, p[4:0]} + {1'b0, s} > 7'h20};
				cmp_stat(t >= 8 ? 2'h0 : t % 4 == 3 ? {1'b0, p[5]} : e);
			end
		end
		load(6'h25, 6'h1f);
		@(negedge mclk) rst_n = 1'b0;
		@(negedge mclk) rst_n = 1'b1;
		apply(6'h20);
		cmp_bit(pass_r_source, 1'b1);
		cmp_word({20'h0, position_latch, size_latch}, 32'h0000_0000);
		stop_test();
	end
endmodule // tb_rsc_rotator_control_unit
`default_nettype wire
